// >>> common/dbg_port_pkg.sv
// constants and types for the single-wire debug port
package dbg_port_pkg;
  localparam int BIT_CYCLES = 16;
  localparam int RX_SAMPLE_AT = 10;
  localparam int TX_ONE_PULSE_AT = 7;
  localparam int TX_ZERO_LOW_UNTIL = 13;
  localparam int SPEEDUP_CYCLES = 1;
  localparam int IDLE_TIMEOUT = 512;
  localparam int STEAL_WAIT = 128;
  localparam logic [15:0] REG_LO = 16'hFF00;
  localparam logic [15:0] REG_HI = 16'hFF06;
  localparam logic [15:0] ROM_LO = 16'hFF20;
  localparam logic [15:0] ROM_HI = 16'hFFFF;
  localparam logic [7:0] OP_ENTER_HALT = 8'h90;
  localparam logic [7:0] OP_RD_MB = 8'hE4;
  localparam logic [7:0] OP_RD_B = 8'hE0;
  localparam logic [7:0] OP_RD_MW = 8'hEC;
  localparam logic [7:0] OP_RD_W = 8'hE8;
  localparam logic [7:0] OP_WR_MB = 8'hC4;
  localparam logic [7:0] OP_WR_B = 8'hC0;
  localparam logic [7:0] OP_WR_MW = 8'hCC;
  localparam logic [7:0] OP_WR_W = 8'hC8;
  localparam logic [7:0] OP_RD_NEXT = 8'h62;
  localparam logic [7:0] OP_RD_PC = 8'h63;
  localparam logic [7:0] OP_RD_SP = 8'h67;
  localparam logic [7:0] OP_WR_NEXT = 8'h42;
  localparam logic [7:0] OP_WR_PC = 8'h43;
  localparam logic [7:0] OP_WR_SP = 8'h47;
  localparam logic [7:0] OP_RESUME = 8'h08;
  localparam logic [7:0] OP_STEP = 8'h10;
  localparam logic [7:0] OP_TAG_RESUME = 8'h18;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACCESS = 3'b011,
    ST_DATA_OUT = 3'b010,
    ST_DATA_IN = 3'b110,
    ST_FW_WAIT = 3'b111
  } cmd_state_t;
endpackage

// >>> hw/single_wire_debug_port.sv
// single-wire debug port: bit framing, time-out and command decoder
module single_wire_debug_port (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic specialSingleChip,
  input wire logic fwEnable,
  input wire logic debugSerialPinIn,
  output logic debugSerialPinOut,
  output logic debugSerialPinOe,
  input wire logic cpuBusFree,
  input wire logic cpuAtBoundary,
  output logic cpuFreeze,
  output logic memReq,
  output logic memWrite,
  output logic memWord,
  output logic [15:0] memAddr,
  output logic [15:0] memWdata,
  output logic [1:0] memByteEn,
  input wire logic memAck,
  input wire logic [15:0] memRdata,
  output logic debugResMapped,
  output logic debugHaltMode,
  output logic periphSuspend,
  output logic fwCmdValid,
  output logic [7:0] fwCmdOpcode,
  output logic [15:0] fwCmdData,
  input wire logic fwRespValid,
  input wire logic [15:0] fwRespData,
  output logic tagEnable,
  output logic stepReq,
  output logic cmdTimeout
);
  import dbg_port_pkg::*;

  function automatic logic isMemRead(input logic [7:0] op);
    return op == OP_RD_MB || op == OP_RD_B || op == OP_RD_MW || op == OP_RD_W;
  endfunction
  function automatic logic isMemWrite(input logic [7:0] op);
    return op == OP_WR_MB || op == OP_WR_B || op == OP_WR_MW || op == OP_WR_W;
  endfunction
  // while halted, debug registers and rom shadow application memory at their addresses
  function automatic logic inHaltMap(input logic [15:0] a);
    return (a >= REG_LO && a <= REG_HI) || a >= ROM_LO;
  endfunction

  // three-stage pin synchroniser; a level counts when stages two and three agree
  logic sync1_ff, sync2_ff, sync3_ff, pinLvl_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
      pinLvl_ff <= 1'b1;
    end else begin
      sync1_ff <= debugSerialPinIn;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) pinLvl_ff <= sync3_ff;
    end
  end
  logic fallEdge;
  // own drive is masked so the target's own low drive of a zero is not a new bit
  assign fallEdge = pinLvl_ff && !sync3_ff && !sync2_ff && !debugSerialPinOe;

  // bit timing
  logic inBit_ff, txMode_ff, txBit_ff;
  logic [4:0] bitCnt_ff;
  logic [9:0] idleCnt_ff;
  logic sampleStb, bitDone;
  assign sampleStb = inBit_ff && bitCnt_ff == 5'(RX_SAMPLE_AT - 1);
  assign bitDone = inBit_ff && bitCnt_ff == 5'(BIT_CYCLES - 1);

  cmd_state_t state_ff;
  logic [15:0] shift_ff;
  logic [4:0] bitsLeft_ff;
  logic [7:0] opcode_ff;
  logic timeout;
  assign timeout = idleCnt_ff == 10'(IDLE_TIMEOUT - 1) && !fallEdge;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      inBit_ff <= 1'b0;
      bitCnt_ff <= 5'h00;
      idleCnt_ff <= 10'h000;
      cmdTimeout <= 1'b0;
    end else begin
      cmdTimeout <= 1'b0;
      if (fallEdge) begin
        inBit_ff <= 1'b1;
        bitCnt_ff <= 5'h00;
        idleCnt_ff <= 10'h000;
      end else begin
        if (bitDone) inBit_ff <= 1'b0;
        bitCnt_ff <= bitCnt_ff + 5'h01;
        if (state_ff == ST_OPCODE && bitsLeft_ff == 5'h08) idleCnt_ff <= 10'h000;
        else if (timeout) begin
          idleCnt_ff <= 10'h000;
          cmdTimeout <= 1'b1;
        end else idleCnt_ff <= idleCnt_ff + 10'h001;
      end
    end
  end

  // transmit drive: zero held low to 13 then pulled high; one gets a pulse at 7
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      debugSerialPinOut <= 1'b1;
      debugSerialPinOe <= 1'b0;
    end else if (inBit_ff && txMode_ff) begin
      if (!txBit_ff && bitCnt_ff < 5'(TX_ZERO_LOW_UNTIL - 1)) begin
        debugSerialPinOut <= 1'b0;
        debugSerialPinOe <= 1'b1;
      end else if (!txBit_ff && bitCnt_ff < 5'(TX_ZERO_LOW_UNTIL - 1 + SPEEDUP_CYCLES)) begin
        debugSerialPinOut <= 1'b1;
        debugSerialPinOe <= 1'b1;
      end else if (txBit_ff && bitCnt_ff >= 5'(TX_ONE_PULSE_AT - 1)
                   && bitCnt_ff < 5'(TX_ONE_PULSE_AT - 1 + SPEEDUP_CYCLES)) begin
        debugSerialPinOut <= 1'b1;
        debugSerialPinOe <= 1'b1;
      end else begin
        debugSerialPinOut <= 1'b1;
        debugSerialPinOe <= 1'b0;
      end
    end else begin
      // pin left undriven while the host sends
      debugSerialPinOut <= 1'b1;
      debugSerialPinOe <= 1'b0;
    end
  end

  // halt mode: active out of reset in special single-chip mode, strap caught at release
  logic strapDone_ff, enterPend_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strapDone_ff <= 1'b0;
      debugHaltMode <= 1'b0;
      enterPend_ff <= 1'b0;
      tagEnable <= 1'b0;
      stepReq <= 1'b0;
    end else begin
      strapDone_ff <= 1'b1;
      stepReq <= 1'b0;
      if (!strapDone_ff) debugHaltMode <= specialSingleChip;
      else if (enterPend_ff && cpuAtBoundary) begin
        debugHaltMode <= 1'b1;
        enterPend_ff <= 1'b0;
      end
      if (state_ff == ST_OPCODE && bitDone && bitsLeft_ff == 5'h01) begin
        if (shift_ff[7:0] == OP_ENTER_HALT && fwEnable)
          enterPend_ff <= 1'b1;
        if (debugHaltMode) begin
          case (shift_ff[7:0])
            OP_RESUME: debugHaltMode <= 1'b0;
            OP_STEP: begin
              debugHaltMode <= 1'b0;
              stepReq <= 1'b1;
              enterPend_ff <= 1'b1;
            end
            OP_TAG_RESUME: begin
              debugHaltMode <= 1'b0;
              tagEnable <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) periphSuspend <= 1'b0;
    else periphSuspend <= debugHaltMode;
  end

  // command decoder; shift register keeps the incoming or outgoing word, msb first
  logic [7:0] stealCnt_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_OPCODE;
      shift_ff <= 16'h0000;
      bitsLeft_ff <= 5'h08;
      opcode_ff <= 8'h00;
      txMode_ff <= 1'b0;
      txBit_ff <= 1'b1;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memWord <= 1'b0;
      memAddr <= 16'h0000;
      memWdata <= 16'h0000;
      memByteEn <= 2'b00;
      debugResMapped <= 1'b0;
      cpuFreeze <= 1'b0;
      stealCnt_ff <= 8'h00;
      fwCmdValid <= 1'b0;
      fwCmdOpcode <= 8'h00;
      fwCmdData <= 16'h0000;
    end else if (timeout) begin
      state_ff <= ST_OPCODE;
      bitsLeft_ff <= 5'h08;
      opcode_ff <= 8'h00;
      txMode_ff <= 1'b0;
      memReq <= 1'b0;
      debugResMapped <= 1'b0;
      cpuFreeze <= 1'b0;
      fwCmdValid <= 1'b0;
    end else begin
      fwCmdValid <= 1'b0;
      if (fallEdge && txMode_ff) txBit_ff <= shift_ff[15];
      case (state_ff)
        ST_OPCODE: if (sampleStb) begin
          shift_ff <= {shift_ff[14:0], sync3_ff};
        end else if (bitDone) begin
          bitsLeft_ff <= bitsLeft_ff - 5'h01;
          if (bitsLeft_ff == 5'h01) begin
            opcode_ff <= shift_ff[7:0];
            bitsLeft_ff <= 5'h10;
            if (isMemRead(shift_ff[7:0]) || isMemWrite(shift_ff[7:0]))
              state_ff <= ST_ADDR;
            else if (debugHaltMode && shift_ff[7:0] >= OP_RD_NEXT
                     && shift_ff[7:0] <= OP_RD_SP) begin
              fwCmdValid <= 1'b1;
              fwCmdOpcode <= shift_ff[7:0];
              state_ff <= ST_FW_WAIT;
            end else if (debugHaltMode && shift_ff[7:0] >= OP_WR_NEXT
                         && shift_ff[7:0] <= OP_WR_SP)
              state_ff <= ST_DATA_IN;
            else bitsLeft_ff <= 5'h08;
          end
        end
        ST_ADDR, ST_DATA_IN: if (sampleStb) begin
          shift_ff <= {shift_ff[14:0], sync3_ff};
        end else if (bitDone) begin
          bitsLeft_ff <= bitsLeft_ff - 5'h01;
          if (bitsLeft_ff == 5'h01) begin
            bitsLeft_ff <= 5'h10;
            if (state_ff == ST_ADDR) begin
              memAddr <= shift_ff;
              if (isMemWrite(opcode_ff)) state_ff <= ST_DATA_IN;
              else state_ff <= ST_ACCESS;
            end else if (isMemWrite(opcode_ff)) begin
              memWdata <= shift_ff;
              state_ff <= ST_ACCESS;
            end else begin
              fwCmdValid <= 1'b1;
              fwCmdOpcode <= opcode_ff;
              fwCmdData <= shift_ff;
              state_ff <= ST_OPCODE;
              bitsLeft_ff <= 5'h08;
            end
          end
        end
        ST_ACCESS: begin
          if (!memReq && !cpuFreeze) begin
            memWrite <= isMemWrite(opcode_ff);
            memWord <= opcode_ff[3];
            if (opcode_ff[3]) begin
              memAddr[0] <= 1'b0;
              memByteEn <= 2'b11;
            end else begin
              memByteEn <= memAddr[0] ? 2'b01 : 2'b10;
            end
            if (cpuBusFree) begin
              memReq <= 1'b1;
              debugResMapped <= opcode_ff[2] || (debugHaltMode && inHaltMap(memAddr));
            end else if (stealCnt_ff == 8'(STEAL_WAIT - 1)) begin
              cpuFreeze <= 1'b1;
            end else stealCnt_ff <= stealCnt_ff + 8'h01;
          end else if (cpuFreeze && !memReq) begin
            memReq <= 1'b1;
            debugResMapped <= opcode_ff[2] || (debugHaltMode && inHaltMap(memAddr));
          end else if (memAck) begin
            memReq <= 1'b0;
            cpuFreeze <= 1'b0;
            debugResMapped <= 1'b0;
            stealCnt_ff <= 8'h00;
            if (memWrite) begin
              state_ff <= ST_OPCODE;
              bitsLeft_ff <= 5'h08;
            end else begin
              shift_ff <= memRdata;
              txMode_ff <= 1'b1;
              txBit_ff <= memRdata[15];
              state_ff <= ST_DATA_OUT;
            end
          end
        end
        ST_FW_WAIT: if (fwRespValid) begin
          shift_ff <= fwRespData;
          txMode_ff <= 1'b1;
          txBit_ff <= fwRespData[15];
          state_ff <= ST_DATA_OUT;
        end
        ST_DATA_OUT: if (bitDone) begin
          shift_ff <= {shift_ff[14:0], 1'b0};
          bitsLeft_ff <= bitsLeft_ff - 5'h01;
          if (bitsLeft_ff == 5'h01) begin
            txMode_ff <= 1'b0;
            state_ff <= ST_OPCODE;
            bitsLeft_ff <= 5'h08;
          end
        end
        default: state_ff <= ST_OPCODE;
      endcase
    end
  end
endmodule

// >>> verification/single_wire_debug_port_checker.sv
// assertions on the debug port pin drive and command side
module single_wire_debug_port_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic specialSingleChip,
  input wire logic debugSerialPinIn,
  input wire logic debugSerialPinOut,
  input wire logic debugSerialPinOe,
  input wire logic cpuFreeze,
  input wire logic memReq,
  input wire logic memWord,
  input wire logic [15:0] memAddr,
  input wire logic [1:0] memByteEn,
  input wire logic memAck,
  input wire logic debugResMapped,
  input wire logic debugHaltMode,
  input wire logic periphSuspend,
  input wire logic fwCmdValid,
  input wire logic cmdTimeout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] idleCnt_ff;
  logic pinPrev_ff;
  wire zeroDrv = debugSerialPinOe && !debugSerialPinOut;
  // cycles since the pin last fell; saturates so long idles stay large
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      idleCnt_ff <= 10'h0;
      pinPrev_ff <= 1'h1;
    end else begin
      pinPrev_ff <= debugSerialPinIn;
      if (pinPrev_ff && !debugSerialPinIn) begin
        idleCnt_ff <= 10'h0;
      end else if (idleCnt_ff != 10'h3FF) begin
        idleCnt_ff <= idleCnt_ff + 10'h1;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  haltReset_a: assert property ($past(sys_rst) && !sys_rst |=>
    debugHaltMode == $past(specialSingleChip)) else $error("halt after reset wrong");
  zeroShape_a: assert property ($rose(debugSerialPinOe) && zeroDrv |->
    zeroDrv[*8] ##1 zeroDrv[*4] ##1 (debugSerialPinOe && debugSerialPinOut) ##1 !debugSerialPinOe)
    else $error("zero bit drive wrong");
  onePulse_a: assert property ($rose(debugSerialPinOe) && debugSerialPinOut |->
    idleCnt_ff inside {[7:12]} ##1 !debugSerialPinOe) else $error("one bit pulse wrong");
  memHold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
    else $error("memory request dropped");
  stealReq_a: assert property ($rose(cpuFreeze) |-> ##[0:3] memReq)
    else $error("freeze without access");
  byteLane_a: assert property (memReq && !memWord |->
    memByteEn == (memAddr[0] ? 2'h1 : 2'h2)) else $error("byte lane wrong");
  wordAlign_a: assert property (memReq && memWord |-> !memAddr[0])
    else $error("word access unaligned");
  mapOnly_a: assert property (debugResMapped |-> memReq || $past(memReq))
    else $error("debug map outside access");
  suspendFollow_a: assert property (periphSuspend == $past(debugHaltMode))
    else $error("suspend not following halt");
  fwHalt_a: assert property (fwCmdValid |-> debugHaltMode)
    else $error("firmware command outside halt");
  timeoutLate_a: assert property (cmdTimeout |-> idleCnt_ff >= 10'h1FC)
    else $error("time-out too early");
endmodule

bind single_wire_debug_port single_wire_debug_port_checker i_chk (.*);

// >>> verification/debug_host_model.sv
// host side of the single-wire debug link
module debug_host_model (
  input wire logic clk_sys,
  input wire logic pinLevel,
  output logic hostOe,
  output logic hostOut
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    hostOe = 1'h1;
    hostOut = 1'h1;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // 20 cycles a bit leaves margin for the target's sync delay
  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      hostOe = 1'h1;
      hostOut = 1'h0;
      gap(v[i] ? 4 : 16);
      hostOut = 1'h1;
      gap(v[i] ? 16 : 4);
    end
  endtask
  task automatic recv(output logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      hostOe = 1'h1;
      hostOut = 1'h0;
      gap(3);
      // released line idles high on the pull-up unless the target holds it low for a zero
      hostOe = 1'h0;
      hostOut = 1'h1;
      gap(8);
      v[i] = pinLevel;
      gap(9);
    end
  endtask
endmodule

// >>> verification/single_wire_debug_port_test.sv
// self-checking bench for the single-wire debug port
module single_wire_debug_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  import dbg_port_pkg::*;
  logic clk_sys, sys_rst, specialSingleChip, fwEnable, cpuBusFree, cpuAtBoundary, memAck;
  logic fwRespValid, debugSerialPinOut, debugSerialPinOe, cpuFreeze, memReq, memWrite;
  logic memWord, debugResMapped, debugHaltMode, periphSuspend, fwCmdValid, tagEnable;
  logic stepReq, cmdTimeout, hostOe, hostOut, lastMap, lastWr;
  logic [1:0] memByteEn, lastBe;
  logic [7:0] fwCmdOpcode, fwOp;
  logic [15:0] memAddr, memWdata, fwCmdData, fwDat, lastAddr, lastData, rx;
  logic [15:0] memRdata = 16'hA55A;
  logic [15:0] fwRespData = 16'hC35A;
  int badCount, checksDone, cycles, fwCnt, stepCnt, toCnt;
  // pull-up holds the line high when nobody drives it
  wire debugSerialPinIn = debugSerialPinOe ? debugSerialPinOut : (hostOe ? hostOut : 1'h1);
  single_wire_debug_port i_dut (.*);
  debug_host_model i_host (.clk_sys, .pinLevel(debugSerialPinIn), .hostOe, .hostOut);
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    memAck <= memReq && !memAck;
    fwRespValid <= fwCmdValid && fwCmdOpcode[5];
    if (memReq && memAck) begin
      {lastAddr, lastData, lastBe, lastMap, lastWr} <= {memAddr, memWdata, memByteEn,
        debugResMapped, memWrite};
    end
    if (fwCmdValid) begin
      {fwOp, fwDat} <= {fwCmdOpcode, fwCmdData};
    end
    fwCnt <= fwCnt + int'(fwCmdValid);
    stepCnt <= stepCnt + int'(stepReq);
    toCnt <= toCnt + int'(cmdTimeout);
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      badCount++;
      testDone();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic testDone();
    if (badCount == 0 && checksDone > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic memCmd(input logic [7:0] op, input logic [15:0] a, d);
    i_host.send({8'h0, op}, 8);
    i_host.send(a, 16);
    if (op[5]) begin
      gap(150);
      i_host.recv(rx);
    end else begin
      i_host.send(d, 16);
      gap(150);
    end
  endtask
  task automatic tFirmware();
    logic [7:0] op;
    for (int k = 2; k < 8; k++) begin
      op = 8'h60 + 8'(k);
      i_host.send({8'h0, op}, 8);
      gap(40);
      i_host.recv(rx);
      check("fw read", {fwOp, rx}, {op, 16'hC35A});
      op = 8'h40 + 8'(k);
      i_host.send({8'h0, op}, 8);
      i_host.send({op, 8'h5A}, 16);
      gap(40);
      check("fw write", {fwOp, fwDat}, {op, op, 8'h5A});
    end
  endtask
  task automatic tMemory();
    int n;
    memCmd(OP_RD_W, 16'h1236, 16'h0);
    check("word read", {lastMap, rx}, 17'h0A55A);
    memCmd(OP_RD_MB, 16'hFF01, 16'h0);
    check("odd byte", {lastMap, lastBe, rx[7:0]}, 11'h55A);
    memCmd(OP_WR_MB, 16'hFF00, 16'h7E00);
    check("even byte", {lastWr, lastMap, lastBe, lastData[15:8]}, 12'hE7E);
    memCmd(OP_WR_W, 16'h2001, 16'hBEEF);
    check("word write", {lastAddr, lastData}, 32'h2000BEEF);
    // still halted here: plain read of the register window sees the debug side
    memCmd(OP_RD_W, 16'hFF02, 16'h0);
    check("halt map", lastMap, 1'h1);
    cpuBusFree = 1'h0;
    i_host.send({8'h0, OP_RD_W}, 8);
    i_host.send(16'h0100, 16);
    n = 0;
    while (!cpuFreeze && n < 200) begin
      gap(1);
      n++;
    end
    check("steal wait", n >= 115 && n <= 135, 1'h1);
    gap(30);
    i_host.recv(rx);
    check("stolen read", rx, 16'hA55A);
    cpuBusFree = 1'h1;
  endtask
  task automatic tFlow();
    int f;
    i_host.send({8'h0, OP_RESUME}, 8);
    gap(70);
    check("resume", debugHaltMode, 1'h0);
    memCmd(OP_RD_W, 16'hFF02, 16'h0);
    check("run unmapped", lastMap, 1'h0);
    f = fwCnt;
    i_host.send({8'h0, OP_RD_PC}, 8);
    gap(40);
    check("fw refused", fwCnt, f);
    fwEnable = 1'h0;
    i_host.send({8'h0, OP_ENTER_HALT}, 8);
    gap(70);
    check("halt refused", debugHaltMode, 1'h0);
    fwEnable = 1'h1;
    i_host.send({8'h0, OP_ENTER_HALT}, 8);
    gap(70);
    check("halt entered", {periphSuspend, debugHaltMode}, 2'h3);
    f = stepCnt;
    i_host.send({8'h0, OP_STEP}, 8);
    gap(70);
    check("step", {stepCnt - f == 1, debugHaltMode}, 2'h3);
    i_host.send({8'h0, OP_TAG_RESUME}, 8);
    gap(70);
    check("tag resume", {tagEnable, debugHaltMode}, 2'h2);
  endtask
  task automatic tTimeout();
    int t;
    t = toCnt;
    i_host.send({8'h0, OP_WR_B}, 8);
    gap(600);
    check("idle timeout", toCnt - t, 1);
    memCmd(OP_RD_W, 16'h0042, 16'h0);
    check("after timeout", rx, 16'hA55A);
  endtask
  initial begin
    sys_rst = 1'h1;
    specialSingleChip = 1'h1;
    fwEnable = 1'h1;
    cpuBusFree = 1'h1;
    cpuAtBoundary = 1'h1;
    gap(6);
    sys_rst = 1'h0;
    gap(4);
    check("reset", {debugHaltMode, periphSuspend, debugSerialPinOe}, 3'h6);
    tFirmware();
    tMemory();
    tFlow();
    tTimeout();
    testDone();
  end
endmodule
